// file: rtl/pca_map.vh
// register map, field positions, reset values and timing for the counter array
`ifndef PCA_MAP_VH
`define PCA_MAP_VH
// special function register addresses
`define PCA_ADDR_CONTROL 8'hD8
`define PCA_ADDR_MODE 8'hD9
`define PCA_ADDR_COUNT_LOW 8'hE9
`define PCA_ADDR_COUNT_HIGH 8'hF9
`define PCA_ADDR_MOD_MODE 8'hDA
`define PCA_ADDR_VAL_LOW 8'hEA
`define PCA_ADDR_VAL_HIGH 8'hFA
// control register fields
`define PCA_CTL_OVF 7
`define PCA_CTL_RUN 6
// mode register fields
`define PCA_MD_IDLE 7
`define PCA_MD_TB_HI 3
`define PCA_MD_TB_LO 1
`define PCA_MD_OVF_IE 0
// module mode register fields
`define PCA_MM_WIDE 7
`define PCA_MM_COMP 6
`define PCA_MM_RISE 5
`define PCA_MM_FALL 4
`define PCA_MM_HIT 3
`define PCA_MM_FLIP 2
`define PCA_MM_PULSE 1
`define PCA_MM_IE 0
// reset values
`define PCA_RST_BYTE 8'h00
`define PCA_RST_MODE 8'h00
// timebase codes
`define PCA_TB_DIV12 3'h0
`define PCA_TB_DIV4 3'h1
`define PCA_TB_T0 3'h2
`define PCA_TB_EXT 3'h3
`define PCA_TB_SYS 3'h4
`define PCA_TB_OSC8 3'h5
// divider terminal counts
`define PCA_DIV12_LAST 4'hB
`define PCA_DIV4_LAST 2'h3
`define PCA_OSC8_LAST 3'h7
// decoded module modes
`define PCA_MODE_NONE 3'h0
`define PCA_MODE_CAPTURE 3'h1
`define PCA_MODE_TIMER 3'h2
`define PCA_MODE_FASTOUT 3'h3
`define PCA_MODE_FREQ 3'h4
`define PCA_MODE_PWM8 3'h5
`define PCA_MODE_WIDE_PULSE_MODE 3'h6
`endif

// file: rtl/pca_array.v
// counter array: timebase, 16-bit counter and five capture/compare modules
`timescale 1ns/1ps
`include "pca_map.vh"
module pca_array (
    input wire i_clock,
    input wire i_srst,
    input wire [7:0] i_sfr_addr,
    input wire i_sfr_wr,
    input wire i_sfr_rd,
    input wire i_sfr_rmw,
    input wire [7:0] i_sfr_wdata,
    output reg [7:0] o_sfr_rdata,
    input wire i_cpu_idle,
    input wire i_global_irq_enable,
    input wire i_array_irq_enable,
    input wire i_timer0_ovf,
    input wire i_ext_count_input,
    input wire i_ext_osc,
    input wire [4:0] i_module_pin,
    output reg o_irq
);

    // decode module mode bits into one mode code
    function [2:0] pca_mode_of;
        input [7:0] m;
        begin
            if (m[`PCA_MM_RISE] || m[`PCA_MM_FALL])
            begin
                if (!m[`PCA_MM_HIT] && !m[`PCA_MM_FLIP] && !m[`PCA_MM_PULSE])
                    pca_mode_of = `PCA_MODE_CAPTURE;
                else
                    pca_mode_of = `PCA_MODE_NONE;
            end
            else if (!m[`PCA_MM_COMP])
                pca_mode_of = `PCA_MODE_NONE;
            else if (m[`PCA_MM_FLIP] && m[`PCA_MM_PULSE])
                pca_mode_of = `PCA_MODE_FREQ;
            else if (m[`PCA_MM_PULSE])
                pca_mode_of = m[`PCA_MM_WIDE] ? `PCA_MODE_WIDE_PULSE_MODE
                                              : `PCA_MODE_PWM8;
            else if (m[`PCA_MM_HIT])
                pca_mode_of = m[`PCA_MM_FLIP] ? `PCA_MODE_FASTOUT
                                              : `PCA_MODE_TIMER;
            else
                pca_mode_of = `PCA_MODE_NONE;
        end
    endfunction

    // address to module index, 3'h7 when not in the given block
    function [2:0] pca_index_of;
        input [7:0] addr;
        input [7:0] base;
        reg [7:0] d;
        begin
            d = addr - base;
            pca_index_of = (d < 8'h05) ? d[2:0] : 3'h7;
        end
    endfunction

    reg [15:0] count;
    reg [7:0] snapshot;
    reg overflow_flag;
    reg counter_run;
    reg idle_suspend;
    reg [2:0] timebase_select;
    reg overflow_irq_enable;
    wire [4:0] event_flag;
    reg [3:0] div_count;
    reg [2:0] osc_div;
    reg osc_s1;
    reg osc_s2;
    reg osc_s3;
    reg ext_s1;
    reg ext_s2;
    reg ext_s3;
    reg tick;
    wire [39:0] all_mode;
    wire [79:0] all_value;
    wire [4:0] hit;
    wire [2:0] mode_idx;
    wire [2:0] low_idx;
    wire [2:0] high_idx;
    wire active;
    wire step;
    wire wrap;
    wire ctl_write;
    wire [4:0] module_irq;

    assign mode_idx = pca_index_of(i_sfr_addr, `PCA_ADDR_MOD_MODE);
    assign low_idx = pca_index_of(i_sfr_addr, `PCA_ADDR_VAL_LOW);
    assign high_idx = pca_index_of(i_sfr_addr, `PCA_ADDR_VAL_HIGH);
    assign ctl_write = i_sfr_wr && (i_sfr_addr == `PCA_ADDR_CONTROL);

    // idle suspend only freezes while the processor really idles
    assign active = counter_run && !(idle_suspend && i_cpu_idle);
    assign step = active && tick;
    assign wrap = step && (count == 16'hFFFF);

    // prescaler for sysclk/12 and sysclk/4, always free running
    always @(posedge i_clock)
    begin
        if (i_srst)
            div_count <= 4'h0;
        else if (div_count == `PCA_DIV12_LAST)
            div_count <= 4'h0;
        else
            div_count <= div_count + 4'h1;
    end

    // oscillator and count input synchronisers; stage one feeds stage two only
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end
        else
        begin
            osc_s1 <= i_ext_osc;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            ext_s1 <= i_ext_count_input;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // oscillator rising edges divided by eight; osc must not beat sysclk
    always @(posedge i_clock)
    begin
        if (i_srst)
            osc_div <= 3'h0;
        else if (osc_s2 && !osc_s3)
            osc_div <= osc_div + 3'h1;
    end

    // timebase pulse, one cycle wide, registered so the mux adds no glitch
    always @(posedge i_clock)
    begin
        if (i_srst)
            tick <= 1'b0;
        else
        begin
            case (timebase_select)
                `PCA_TB_DIV12: tick <= (div_count == `PCA_DIV12_LAST);
                `PCA_TB_DIV4: tick <= (div_count[1:0] == `PCA_DIV4_LAST);
                `PCA_TB_T0: tick <= i_timer0_ovf;
                `PCA_TB_EXT: tick <= !ext_s2 && ext_s3;
                `PCA_TB_SYS: tick <= 1'b1;
                `PCA_TB_OSC8: tick <= osc_s2 && !osc_s3 &&
                                      (osc_div == `PCA_OSC8_LAST);
                default: tick <= 1'b0;
            endcase
        end
    end

    // counter; software byte writes take priority over an increment
    always @(posedge i_clock)
    begin
        if (i_srst)
            count <= 16'h0000;
        else if (i_sfr_wr && (i_sfr_addr == `PCA_ADDR_COUNT_LOW))
            count[7:0] <= i_sfr_wdata;
        else if (i_sfr_wr && (i_sfr_addr == `PCA_ADDR_COUNT_HIGH))
            count[15:8] <= i_sfr_wdata;
        else if (step)
            count <= count + 16'h0001;
    end

    // mode register
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            idle_suspend <= 1'b0;
            timebase_select <= `PCA_TB_DIV12;
            overflow_irq_enable <= 1'b0;
        end
        else if (i_sfr_wr && (i_sfr_addr == `PCA_ADDR_MODE))
        begin
            idle_suspend <= i_sfr_wdata[`PCA_MD_IDLE];
            timebase_select <= i_sfr_wdata[`PCA_MD_TB_HI:`PCA_MD_TB_LO];
            overflow_irq_enable <= i_sfr_wdata[`PCA_MD_OVF_IE];
        end
    end

    // control register; a plain write loses to a new overflow, but a
    // read-modify-write in flight overwrites it as the hardware does
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            overflow_flag <= 1'b0;
            counter_run <= 1'b0;
        end
        else
        begin
            if (ctl_write)
                counter_run <= i_sfr_wdata[`PCA_CTL_RUN];
            if (ctl_write && i_sfr_rmw)
                overflow_flag <= i_sfr_wdata[`PCA_CTL_OVF];
            else if (wrap)
                overflow_flag <= 1'b1;
            else if (ctl_write)
                overflow_flag <= i_sfr_wdata[`PCA_CTL_OVF];
        end
    end

    // per module: pin synchroniser, mode, value pair and event flag
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_module
            reg pin_s1;
            reg pin_s2;
            reg pin_s3;
            reg flag;
            reg [7:0] module_mode_reg;
            reg [15:0] value;
            wire [2:0] mode;
            wire rise;
            wire fall;
            wire capture;
            wire match;

            assign mode = pca_mode_of(module_mode_reg);
            assign rise = pin_s2 && !pin_s3;
            assign fall = !pin_s2 && pin_s3;
            // two-stage sync plus edge check needs the two-clock hold
            assign capture = (mode == `PCA_MODE_CAPTURE) && !(idle_suspend &&
                             i_cpu_idle) &&
                             ((rise && module_mode_reg[`PCA_MM_RISE]) ||
                              (fall && module_mode_reg[`PCA_MM_FALL]));
            // compare on the value the counter is about to take
            assign match = step && ((mode == `PCA_MODE_TIMER) ||
                           (mode == `PCA_MODE_FASTOUT)) &&
                           ((count + 16'h0001) == value);
            assign hit[gi] = capture || match;
            assign all_mode[gi*8 +: 8] = module_mode_reg;
            assign all_value[gi*16 +: 16] = value;

            always @(posedge i_clock)
            begin
                if (i_srst)
                begin
                    pin_s1 <= 1'b0;
                    pin_s2 <= 1'b0;
                    pin_s3 <= 1'b0;
                end
                else
                begin
                    pin_s1 <= i_module_pin[gi];
                    pin_s2 <= pin_s1;
                    pin_s3 <= pin_s2;
                end
            end

            // value byte writes also steer the comparator-on bit
            always @(posedge i_clock)
            begin
                if (i_srst)
                    module_mode_reg <= `PCA_RST_MODE;
                else if (i_sfr_wr && (low_idx == gi))
                    module_mode_reg[`PCA_MM_COMP] <= 1'b0;
                else if (i_sfr_wr && (high_idx == gi))
                    module_mode_reg[`PCA_MM_COMP] <= 1'b1;
                else if (i_sfr_wr && (mode_idx == gi))
                    module_mode_reg <= i_sfr_wdata;
            end

            // capture beats a software write in the same cycle
            always @(posedge i_clock)
            begin
                if (i_srst)
                    value <= 16'h0000;
                else if (capture)
                    value <= count;
                else if (i_sfr_wr && (low_idx == gi))
                    value[7:0] <= i_sfr_wdata;
                else if (i_sfr_wr && (high_idx == gi))
                    value[15:8] <= i_sfr_wdata;
            end

            // sticky flag: a new event wins over a software clear
            always @(posedge i_clock)
            begin
                if (i_srst)
                    flag <= 1'b0;
                else if (hit[gi])
                    flag <= 1'b1;
                else if (ctl_write)
                    flag <= i_sfr_wdata[gi];
            end

            assign event_flag[gi] = flag;
            assign module_irq[gi] = flag &&
                                    module_mode_reg[`PCA_MM_IE];
        end
    endgenerate

    // low byte read freezes the high byte for the following read
    always @(posedge i_clock)
    begin
        if (i_srst)
            snapshot <= `PCA_RST_BYTE;
        else if (i_sfr_rd && (i_sfr_addr == `PCA_ADDR_COUNT_LOW))
            snapshot <= count[15:8];
    end

    // read data, valid the cycle after the strobe; unmapped reads zero
    always @(posedge i_clock)
    begin
        if (i_srst)
            o_sfr_rdata <= `PCA_RST_BYTE;
        else if (!i_sfr_rd)
            o_sfr_rdata <= o_sfr_rdata;
        else if (i_sfr_addr == `PCA_ADDR_CONTROL)
            o_sfr_rdata <= {overflow_flag, counter_run, 1'b0, event_flag};
        else if (i_sfr_addr == `PCA_ADDR_MODE)
            o_sfr_rdata <= {idle_suspend, 3'h0, timebase_select,
                            overflow_irq_enable};
        else if (i_sfr_addr == `PCA_ADDR_COUNT_LOW)
            o_sfr_rdata <= count[7:0];
        else if (i_sfr_addr == `PCA_ADDR_COUNT_HIGH)
            o_sfr_rdata <= snapshot;
        else if (mode_idx != 3'h7)
            o_sfr_rdata <= all_mode[mode_idx*8 +: 8];
        else if (low_idx != 3'h7)
            o_sfr_rdata <= all_value[low_idx*16 +: 8];
        else if (high_idx != 3'h7)
            o_sfr_rdata <= all_value[high_idx*16+8 +: 8];
        else
            o_sfr_rdata <= `PCA_RST_BYTE;
    end

    // one interrupt line behind both processor enables
    always @(posedge i_clock)
    begin
        if (i_srst)
            o_irq <= 1'b0;
        else
            o_irq <= i_global_irq_enable && i_array_irq_enable &&
                     ((overflow_flag && overflow_irq_enable) ||
                      (|module_irq));
    end

endmodule // pca_array

// file: tb/pca_array_asserts.sv
// port-level checker for the counter array
`timescale 1ns/1ps
module pca_array_asserts (
    input wire i_clock,
    input wire i_srst,
    input wire [7:0] i_sfr_addr,
    input wire i_sfr_wr,
    input wire i_sfr_rd,
    input wire [7:0] o_sfr_rdata,
    input wire i_global_irq_enable,
    input wire i_array_irq_enable,
    input wire o_irq
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    // quiet outputs on leaving reset
    chk_rst_quiet: assert property ($fell(i_srst) |-> !o_irq && o_sfr_rdata == 8'h00)
        else $error("outputs not idle after reset");
    // read data stands until the next read
    chk_read_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (i_sfr_rd && i_sfr_addr == 8'h01
        |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_ctl_spare: assert property (i_sfr_rd && i_sfr_addr == 8'hD8
        |=> !o_sfr_rdata[5])
        else $error("control spare bit set");
    chk_mode_spare: assert property (i_sfr_rd && i_sfr_addr == 8'hD9
        |=> o_sfr_rdata[6:4] == 3'h0)
        else $error("mode spare bits set");
    chk_irq_global: assert property (!i_global_irq_enable |=> !o_irq)
        else $error("irq without global enable");
    chk_irq_array: assert property (!i_array_irq_enable |=> !o_irq)
        else $error("irq without array enable");
    // flags are sticky: only a write, seen one cycle late, drops the request
    chk_irq_sticky: assert property (o_irq && i_global_irq_enable
        && i_array_irq_enable && !i_sfr_wr && !$past(i_sfr_wr)
        |=> o_irq)
        else $error("irq dropped without a write");

    cover property (o_irq);
    cover property (i_sfr_rd && i_sfr_addr == 8'hF9);
    cover property ($fell(o_irq));
endmodule // pca_array_asserts

// file: tb/pca_pins.sv
// free-running external sources beside the counter array
`timescale 1ns/1ps
module pca_pins (
    input wire i_clock,
    output logic o_timer0_ovf,
    output logic o_ext_count_input,
    output logic o_ext_osc
);
    logic [4:0] phase = 5'h00;

    // 24-cycle frame keeps every source strictly periodic
    always @(posedge i_clock)
    begin
        phase <= #1 (phase == 5'h17) ? 5'h00 : phase + 5'h01;
    end
    assign o_timer0_ovf = (phase % 6) == 0;
    assign o_ext_count_input = phase[2];
    assign o_ext_osc = phase[0];
endmodule // pca_pins

// file: tb/pca_array_bench.sv
// self-checking bench for the counter array
`timescale 1ns/1ps
module pca_array_bench;
    logic clk, srst, wr, rd, rmw, idle, gie, aie, t0, ext_count_input, osc, irq, hit;
    logic [7:0] addr, wd, rdat, v, rv, lo, hi;
    logic [4:0] pin;
    logic [15:0] c, want;
    int err_total = 0, check_count = 0, cycles = 0, i, n, k;
    logic [7:0] tmode [11] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
        8'h0C, 8'h0E, 8'h08, 8'h08, 8'h88};
    logic [7:0] texp [11] = '{8'h04, 8'h0C, 8'h08, 8'h06, 8'h30, 8'h03,
        8'h00, 8'h00, 8'h00, 8'h30, 8'h00};
    logic [7:0] rz [11] = '{8'hD8, 8'hD9, 8'hE9, 8'hF9, 8'hDA, 8'hEA,
        8'hFA, 8'hDE, 8'hEE, 8'hFE, 8'h01};

    pca_array i_pca_array (.i_clock(clk), .i_srst(srst), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_rmw(rmw), .i_sfr_wdata(wd),
        .o_sfr_rdata(rdat), .i_cpu_idle(idle), .i_global_irq_enable(gie),
        .i_array_irq_enable(aie), .i_timer0_ovf(t0),
        .i_ext_count_input(ext_count_input), .i_ext_osc(osc), .i_module_pin(pin),
        .o_irq(irq));
    pca_pins i_pca_pins (.i_clock(clk), .o_timer0_ovf(t0),
        .o_ext_count_input(ext_count_input), .o_ext_osc(osc));

    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    // every step starts and ends just after a rising edge
    task automatic cyc(input int m);
        repeat (m) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input [7:0] a, input [7:0] d, input r = 1'b0);
        addr = a;
        wd = d;
        rmw = r;
        wr = 1;
        cyc(1);
        wr = 0;
        rmw = 0;
        cyc(1);
    endtask
    task automatic rd_reg(input [7:0] a, output [7:0] d);
        addr = a;
        rd = 1;
        cyc(1);
        rd = 0;
        d = rdat;
        cyc(1);
    endtask
    task automatic chk(input [15:0] got, input [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            print_verdict;
        end
    end

    initial
    begin
        srst = 1;
        {wr, rd, rmw, idle} = 4'h0;
        {gie, aie} = 2'h3;
        addr = 8'h00;
        wd = 8'h00;
        pin = 5'h00;
        v = 8'($urandom(32'h3D7A096A));
        cyc(12);
        srst = 0;
        cyc(1);
        // reset values of the main registers, modules 0 and 4, one unmapped
        for (i = 0; i < 11; i++)
        begin
            rd_reg(rz[i], v);
            chk(v, 8'h00);
        end
        v = 8'($urandom);
        wr_reg(8'hD9, v);
        rd_reg(8'hD9, rv);
        chk(rv, v & 8'h8F);
        // rate over 48 cycles per timebase, run bit and idle setting
        for (i = 0; i < 11; i++)
        begin
            idle = (i > 8);
            wr_reg(8'hD9, tmode[i]);
            wr_reg(8'hD8, (i == 8) ? 8'h00 : 8'h40);
            cyc(30);
            rd_reg(8'hE9, v);
            cyc(46);
            rd_reg(8'hE9, rv);
            chk(8'(rv - v), texp[i]);
        end
        idle = 0;
        // high read returns the snapshot, not the live byte
        wr_reg(8'hD8, 8'h00);
        wr_reg(8'hF9, 8'h12);
        wr_reg(8'hE9, 8'hFF);
        rd_reg(8'hE9, v);
        wr_reg(8'hF9, 8'h34);
        rd_reg(8'hF9, v);
        chk(v, 8'h12);
        rd_reg(8'hE9, v);
        rd_reg(8'hF9, v);
        chk(v, 8'h34);
        // control write landing on the wrap edge, read-modify-write then plain
        for (i = 0; i < 2; i++)
        begin
            wr_reg(8'hD8, 8'h00);
            wr_reg(8'hD9, 8'h09);
            wr_reg(8'hF9, 8'hFF);
            wr_reg(8'hE9, 8'hFA);
            wr_reg(8'hD8, 8'h40);
            // guarded bit operation: interrupts off, high byte before and after
            gie = 0;
            rd_reg(8'hE9, v);
            rd_reg(8'hF9, hi);
            wr_reg(8'hD8, 8'h40, !i[0]);
            rd_reg(8'hD8, rv);
            chk(rv[7], i[0]);
            rd_reg(8'hE9, v);
            rd_reg(8'hF9, lo);
            chk({hi, lo}, 16'hFF00);
            // a wrap lost to the write-back is put back by hand
            if (hi == 8'hFF && lo == 8'h00 && !rv[7])
                wr_reg(8'hD8, 8'hC0);
            gie = 1;
            rd_reg(8'hD8, rv);
            chk(rv[7], 1'b1);
        end
        chk(irq, 1'b1);
        cyc(20);
        chk(irq, 1'b1);
        gie = 0;
        cyc(2);
        chk(irq, 1'b0);
        gie = 1;
        aie = 0;
        cyc(2);
        chk(irq, 1'b0);
        aie = 1;
        wr_reg(8'hD8, 8'h00);
        chk(irq, 1'b0);
        // edge capture per module, rising then falling pin edge
        for (n = 0; n < 5; n++)
        begin
            want = 16'h0000;
            for (i = 0; i < 3; i++)
            begin
                v = (i == 0) ? 8'h21 : (i == 1) ? 8'h11 : 8'h31;
                wr_reg(8'(8'hDA + n), v);
                for (k = 0; k < 2; k++)
                begin
                    c = 16'($urandom);
                    wr_reg(8'hF9, c[15:8]);
                    wr_reg(8'hE9, c[7:0]);
                    pin[n] = !pin[n];
                    cyc(6);
                    hit = k ? v[4] : v[5];
                    if (hit)
                        want = c;
                    chk(irq, hit);
                    rd_reg(8'(8'hEA + n), lo);
                    rd_reg(8'(8'hFA + n), hi);
                    chk({hi, lo}, want);
                    rd_reg(8'hD8, rv);
                    chk(rv[n], hit);
                    wr_reg(8'hD8, 8'h00);
                end
            end
        end
        // software timer and fast output: match on value 0x0040
        for (i = 0; i < 2; i++)
        begin
            wr_reg(8'hF9, 8'h00);
            wr_reg(8'hE9, 8'h00);
            wr_reg(8'(8'hDA + i), i ? 8'h4D : 8'h49);
            wr_reg(8'(8'hEA + i), 8'h40);
            rd_reg(8'(8'hDA + i), v);
            chk(v, i ? 8'h0D : 8'h09);
            wr_reg(8'(8'hFA + i), 8'h00);
            rd_reg(8'(8'hDA + i), v);
            chk(v, i ? 8'h4D : 8'h49);
            wr_reg(8'hD8, 8'h40);
            cyc(40);
            chk(irq, 1'b0);
            cyc(40);
            chk(irq, 1'b1);
            rd_reg(8'hD8, v);
            chk(v[i], 1'b1);
            wr_reg(8'hD8, 8'h00);
        end
        print_verdict;
    end
endmodule // pca_array_bench

bind pca_array pca_array_asserts i_pca_array_asserts (
    .i_clock(i_clock), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
    .i_global_irq_enable(i_global_irq_enable),
    .i_array_irq_enable(i_array_irq_enable), .o_irq(o_irq));
